// ===== design/scdc_top.sv
// System clock selection, fast RC divider, idle and doze control.
// Assumes source ticks are one-cycle enables from logic on clk, and that
// por is raised together with rst at power-on.
`timescale 1ns/1ps
`default_nettype none
module scdc_top
  import scdc_pkg::*;
(
  // Clock and resets.
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por,
  // Register port.
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // Configuration words.
  input  wire logic [2:0]  reset_source_config,
  input  wire logic [1:0]  primary_mode_config,
  input  wire logic [1:0]  switch_monitor_config,
  input  wire logic        watchdog_enable,
  // Oscillator ticks and PLL status.
  input  wire scdc_ticks_s ticks,
  input  wire logic        pll_locked,
  input  wire logic        clock_fail_event,
  // Power-save and wake sources.
  input  wire logic        idle_request,
  input  wire logic        irq_pending,
  input  wire logic        reset_event,
  input  wire logic        watchdog_timeout,
  // Clock enables and controls out.
  output logic             instruction_clock,
  output logic             periph_clock,
  output logic             cpu_clock,
  output logic             pll_enable,
  output logic             pll_from_primary,
  output logic             divided_fast_rc,
  output logic             watchdog_ref_tick,
  output logic             slow_rc_run,
  output logic             watchdog_clear,
  output logic             cpu_resume,
  output logic             idle_active,
  output logic             pin_select_lock,
  output logic [15:0]      pin_select_value
);

  // All state of the controller in one record.
  typedef struct packed {
    logic [2:0]  cur;        // Active source.
    logic [2:0]  nxt;        // Requested source.
    logic        sw_lock;    // Switch lock.
    logic        pin_lock;   // Pin-select lock.
    logic        fail;       // Clock fail flag.
    logic        sec_en;     // Secondary oscillator enable.
    logic        sw_req;     // Switch request.
    logic [1:0]  mon_cfg;    // Switch and monitor config, caught at power-on.
    logic        interrupt_restores_speed;        // Interrupt restores speed.
    logic [2:0]  doze;       // Doze ratio code.
    logic        doze_en;    // Core slowdown enable.
    logic [2:0]  fast_rc_divider;     // Fast RC divider code.
    logic [15:0] pin_sel;    // Pin-select register.
    logic [1:0]  key;        // Unlock progress: 0 none, 1 first key, 2 armed.
    logic [7:0]  frc_cnt;    // Fast RC divide-by-n counter.
    logic [3:0]  div16_cnt;  // Fast RC divide-by-16 counter.
    logic        phase;      // Divide-by-two phase.
    logic [6:0]  doze_cnt;   // Doze prescaler.
    scdc_ps_e    ps;         // Power-save state.
    logic [1:0]  wake_cnt;   // Wake delay counter.
    logic        icy;        // Instruction clock enable.
    logic        cpu;        // CPU clock enable.
    logic        wd_clr;     // Watchdog clear pulse.
    logic        resume;     // Resume pulse.
    logic        wd_tick;    // Watchdog reference tick.
    logic [15:0] rdata;      // Read data.
  } scdc_state_s;

  scdc_state_s st_r;
  scdc_state_s st_nxt;

  // Last count of a divide by 2^(code+1).
  function automatic logic [7:0] frc_last(input logic [2:0] code);
    logic [8:0] v;
    v = 9'(9'h002 << code) - 9'h001;
    return v[7:0];
  endfunction

  // Last count of a divide by 2^code.
  function automatic logic [6:0] doze_last(input logic [2:0] code);
    logic [7:0] v;
    v = 8'(8'h01 << code) - 8'h01;
    return v[6:0];
  endfunction

  // True for sources that pass through the PLL.
  function automatic logic is_pll(input logic [2:0] s);
    return (s == SRC_FRCN_PLL) || (s == SRC_PRI_PLL);
  endfunction

  // Power-on source from the configuration words.
  function automatic logic [2:0] cfg_source(input logic [2:0] s, input logic [1:0] pm);
    logic [2:0] r;
    r = s;
    // Blank configuration or a primary choice, each only with the primary off, falls back to fast RC.
    if ((s == SRC_CFG_BLANK) && (pm == PRI_MODE_OFF)) begin
      r = SRC_FRC;
    end else if (((s == SRC_PRI) || (s == SRC_PRI_PLL)) && (pm == PRI_MODE_OFF)) begin
      r = SRC_FRC;
    end
    return r;
  endfunction

  // Combinational helpers.
  logic       frcn_tick;   // Divided fast RC tick.
  logic       frc16_tick;  // Fast RC divided by 16.
  logic       fosc_tick;   // Selected oscillator tick.
  logic       osc_wr_ok;   // Oscillator control write passes the unlock.
  logic       sw_allowed;  // Clock switch permitted.
  logic       wake;        // Any wake cause.
  logic       pll_ok;      // Lock status bit.

  // Divider ticks and the source multiplexer.
  always_comb begin
    frcn_tick  = ticks.fast_internal_rc && (st_r.frc_cnt == frc_last(st_r.fast_rc_divider));
    frc16_tick = ticks.fast_internal_rc && (st_r.div16_cnt == 4'hF);
    unique case (st_r.cur)
      SRC_FRC:      fosc_tick = ticks.fast_internal_rc;
      SRC_FRCN_PLL: fosc_tick = ticks.pll;
      SRC_PRI:      fosc_tick = ticks.primary;
      SRC_PRI_PLL:  fosc_tick = ticks.pll;
      SRC_SEC:      fosc_tick = ticks.secondary;
      SRC_SLOW:     fosc_tick = ticks.slow_rc;
      SRC_FRC16:    fosc_tick = frc16_tick;
      SRC_FRCN:     fosc_tick = frcn_tick;
    endcase
  end

  // Access checks and status terms.
  always_comb begin
    osc_wr_ok  = wr && (addr == ADDR_OSC_CTRL) && (st_r.key == 2'h2);
    // Switching is off when the upper config bit is set; lock matters only in mode 01.
    sw_allowed = !st_r.mon_cfg[1] && !((st_r.mon_cfg == MON_SW_ONLY) && st_r.sw_lock);
    wake       = irq_pending || reset_event || watchdog_timeout;
    pll_ok     = is_pll(st_r.cur) && pll_locked;
  end

  // Next-state logic for every field.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wd_clr  = 1'b0;
    st_nxt.resume  = 1'b0;
    st_nxt.icy     = 1'b0;
    st_nxt.cpu     = 1'b0;
    st_nxt.wd_tick = 1'b0;

    // Divider counters run from the fast RC tick.
    if (ticks.fast_internal_rc) begin
      st_nxt.frc_cnt   = frcn_tick ? 8'h00 : st_r.frc_cnt + 8'h01;
      st_nxt.div16_cnt = st_r.div16_cnt + 4'h1;
    end

    // The oscillator tick is halved into the instruction clock.
    if (fosc_tick) begin
      st_nxt.phase = !st_r.phase;
      st_nxt.icy   = st_r.phase;
    end

    // Doze gates only the CPU enable; peripherals keep every instruction tick.
    if (fosc_tick && st_r.phase) begin
      if (!st_r.doze_en || (st_r.doze_cnt == doze_last(st_r.doze))) begin
        st_nxt.doze_cnt = 7'h00;
        st_nxt.cpu      = (st_r.ps == PS_RUN);
      end else begin
        st_nxt.doze_cnt = st_r.doze_cnt + 7'h01;
      end
    end

    // The slow RC tick reaches the watchdog while the oscillator runs.
    st_nxt.wd_tick = ticks.slow_rc && slow_rc_run;

    // Unlock sequence: two keys back to back arm one following write.
    if (wr) begin
      if ((addr == ADDR_UNLOCK) && (wdata == UNLOCK_KEY1)) begin
        st_nxt.key = 2'h1;
      end else if ((addr == ADDR_UNLOCK) && (wdata == UNLOCK_KEY2) && (st_r.key == 2'h1)) begin
        st_nxt.key = 2'h2;
      end else begin
        // Any other write uses up or breaks the sequence.
        st_nxt.key = 2'h0;
      end
    end

    // Oscillator control write, discarded unless armed.
    if (osc_wr_ok) begin
      st_nxt.nxt      = wdata[NXT_LSB +: 3];
      st_nxt.sw_lock  = wdata[SW_LOCK_BIT];
      st_nxt.pin_lock = wdata[PIN_LOCK_BIT];
      st_nxt.sec_en   = wdata[SEC_EN_BIT];
      st_nxt.sw_req   = wdata[SW_REQ_BIT];
      // The fail flag is clear-only from software.
      st_nxt.fail     = st_r.fail && wdata[FAIL_BIT];
    end
    // A fail event wins over a clear in the same cycle.
    if (clock_fail_event) begin
      st_nxt.fail = 1'b1;
    end

    // A pending switch completes when permitted and clears the request.
    if (st_r.sw_req && sw_allowed) begin
      st_nxt.cur    = st_r.nxt;
      // A request written in the completing cycle stays pending, so the set wins.
      st_nxt.sw_req = osc_wr_ok && wdata[SW_REQ_BIT];
    end else if (st_r.sw_req && !st_r.mon_cfg[1] && !osc_wr_ok) begin
      // A blocked request stays pending until unlocked.
      st_nxt.sw_req = 1'b1;
    end else if (st_r.mon_cfg[1] && !osc_wr_ok) begin
      // With switching disabled a request is dropped.
      st_nxt.sw_req = 1'b0;
    end

    // Clock divider write.
    if (wr && (addr == ADDR_CLK_DIV)) begin
      st_nxt.interrupt_restores_speed     = wdata[ROI_BIT];
      st_nxt.doze    = wdata[DOZE_LSB +: 3];
      st_nxt.doze_en = wdata[DOZE_EN_BIT];
      st_nxt.fast_rc_divider  = wdata[FAST_RC_DIVIDER_LSB +: 3];
    end else if (st_r.interrupt_restores_speed && irq_pending) begin
      // Software setting doze in the same cycle keeps it set.
      st_nxt.doze_en = 1'b0;
    end

    // Pin-select writes are discarded while locked.
    if (wr && (addr == ADDR_PIN_SEL) && !st_r.pin_lock) begin
      st_nxt.pin_sel = wdata;
    end

    // Power-save sequencing.
    unique case (st_r.ps)
      PS_RUN: begin
        if (idle_request) begin
          st_nxt.ps     = PS_IDLE;
          st_nxt.wd_clr = 1'b1;
        end
      end
      PS_IDLE: begin
        // Wake is checked only once idle is entered, so a coincident interrupt stays pending.
        if (wake) begin
          st_nxt.ps       = PS_WAKE;
          st_nxt.wake_cnt = WAKE_CYC;
        end
      end
      PS_WAKE: begin
        if (st_r.wake_cnt == 2'h0) begin
          st_nxt.ps     = PS_RUN;
          st_nxt.resume = 1'b1;
        end else begin
          st_nxt.wake_cnt = st_r.wake_cnt - 2'h1;
        end
      end
    endcase

    // Read data, one cycle after the strobe; unmapped bits read zero.
    st_nxt.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        ADDR_OSC_CTRL: begin
          st_nxt.rdata[CUR_LSB +: 3]  = st_r.cur;
          st_nxt.rdata[NXT_LSB +: 3]  = st_r.nxt;
          st_nxt.rdata[SW_LOCK_BIT]   = st_r.sw_lock;
          st_nxt.rdata[PIN_LOCK_BIT]  = st_r.pin_lock;
          st_nxt.rdata[PLL_LOCK_BIT]  = pll_ok;
          st_nxt.rdata[FAIL_BIT]      = st_r.fail;
          st_nxt.rdata[SEC_EN_BIT]    = st_r.sec_en;
          st_nxt.rdata[SW_REQ_BIT]    = st_r.sw_req;
        end
        ADDR_CLK_DIV: begin
          st_nxt.rdata[ROI_BIT]        = st_r.interrupt_restores_speed;
          st_nxt.rdata[DOZE_LSB +: 3]  = st_r.doze;
          st_nxt.rdata[DOZE_EN_BIT]    = st_r.doze_en;
          st_nxt.rdata[FAST_RC_DIVIDER_LSB +: 3] = st_r.fast_rc_divider;
        end
        ADDR_PIN_SEL: st_nxt.rdata = st_r.pin_sel;
        // The unlock register is write-only.
        ADDR_UNLOCK:  st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // State register; oscillator control survives every reset but power-on.
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
    if (rst || por) begin
      st_r.interrupt_restores_speed       <= 1'b0;
      st_r.doze      <= DOZE_RST;
      st_r.doze_en   <= 1'b0;
      st_r.fast_rc_divider    <= FAST_RC_DIVIDER_RST;
      st_r.pin_sel   <= 16'h0000;
      st_r.key       <= 2'h0;
      st_r.frc_cnt   <= 8'h00;
      st_r.div16_cnt <= 4'h0;
      st_r.phase     <= 1'b0;
      st_r.doze_cnt  <= 7'h00;
      st_r.ps        <= PS_RUN;
      st_r.wake_cnt  <= 2'h0;
      st_r.icy       <= 1'b0;
      st_r.cpu       <= 1'b0;
      st_r.wd_clr    <= 1'b0;
      st_r.resume    <= 1'b0;
      st_r.wd_tick   <= 1'b0;
      st_r.rdata     <= 16'h0000;
    end
    // Configuration is caught by this clocked load, not by a reset value.
    if (por) begin
      st_r.cur      <= cfg_source(reset_source_config, primary_mode_config);
      st_r.nxt      <= cfg_source(reset_source_config, primary_mode_config);
      st_r.mon_cfg  <= switch_monitor_config;
      st_r.sw_lock  <= 1'b0;
      st_r.pin_lock <= 1'b0;
      st_r.fail     <= 1'b0;
      st_r.sec_en   <= 1'b0;
      st_r.sw_req   <= 1'b0;
    end
  end

  // Outputs.
  assign rdata             = st_r.rdata;
  assign instruction_clock = st_r.icy;
  assign periph_clock      = st_r.icy;
  assign cpu_clock         = st_r.cpu;
  assign pll_enable        = is_pll(st_r.cur);
  assign pll_from_primary  = (st_r.cur == SRC_PRI_PLL);
  assign divided_fast_rc   = frcn_tick;
  assign watchdog_ref_tick = st_r.wd_tick;
  // Slow RC keeps running when the watchdog or the fail monitor needs it.
  assign slow_rc_run       = watchdog_enable || (st_r.mon_cfg == MON_ALL_ON);
  assign watchdog_clear    = st_r.wd_clr;
  assign cpu_resume        = st_r.resume;
  assign idle_active       = (st_r.ps != PS_RUN);
  assign pin_select_lock   = st_r.pin_lock;
  assign pin_select_value  = st_r.pin_sel;

endmodule
`default_nettype wire

// ===== design/scdc_pkg.sv
// Constants, types and the register map of the system clock and doze controller.
// Assumes one 10 MHz clock and source ticks made by logic on that clock.
// Function
// - Fast RC divided by 1:2 to 1:256.
// - Power-on source from configuration, default fast RC.
// - Instruction and peripheral clock equal source over two.
// - Slow RC feeds watchdog and fail monitor.
// - Current source field, read-only, bits 14-12.
// - Writable requested source, loaded at power-on.
// - Switch lock blocks switching in mode 01.
// - Pin-select lock discards pin-select writes.
// - Lock status shows PLL lock while a PLL source is selected.
// - Oscillator control writes need unlock sequence.
// - Oscillator control reset only by power-on.
// - Idle halts CPU, peripherals keep clock.
// - Idle entry clears the watchdog counter.
// - Slow RC stays on when watchdog/monitor enabled.
// - Interrupt, reset or watchdog time-out ends idle.
// - CPU resumes 2 to 4 cycles after wake.
// - Interrupt during entry wakes after entry completes.
// - Doze slows only the CPU clock.
// - Doze ratio field, 1:1 to 1:128, default 1:1.
// - Return-on-interrupt ends doze on interrupt.
// - Fast RC and primary may pass the PLL.
package scdc_pkg;
  // Register indices on the plain port.
  localparam logic [1:0]  ADDR_OSC_CTRL = 2'h0;
  localparam logic [1:0]  ADDR_CLK_DIV  = 2'h1;
  localparam logic [1:0]  ADDR_UNLOCK   = 2'h2;
  localparam logic [1:0]  ADDR_PIN_SEL  = 2'h3;
  // Unlock keys, written in this order back to back.
  localparam logic [15:0] UNLOCK_KEY1   = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY2   = 16'h00AA;
  // Oscillator control field positions.
  localparam int CUR_LSB = 12;
  localparam int NXT_LSB = 8;
  localparam int SW_LOCK_BIT = 7;
  localparam int PIN_LOCK_BIT = 6;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SW_REQ_BIT = 0;
  // Clock divider field positions.
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int DOZE_EN_BIT = 11;
  localparam int FAST_RC_DIVIDER_LSB = 8;
  // Reset values of the clock divider fields.
  localparam logic [2:0]  DOZE_RST = 3'h0;
  localparam logic [2:0]  FAST_RC_DIVIDER_RST = 3'h0;
  // Source encodings shared by current and requested source.
  localparam logic [2:0]  SRC_FRC       = 3'h0;
  localparam logic [2:0]  SRC_FRCN_PLL  = 3'h1;
  localparam logic [2:0]  SRC_PRI       = 3'h2;
  localparam logic [2:0]  SRC_PRI_PLL   = 3'h3;
  localparam logic [2:0]  SRC_SEC       = 3'h4;
  localparam logic [2:0]  SRC_SLOW      = 3'h5;
  localparam logic [2:0]  SRC_FRC16     = 3'h6;
  localparam logic [2:0]  SRC_FRCN      = 3'h7;
  // Configuration codes.
  localparam logic [1:0]  PRI_MODE_OFF  = 2'h3;
  localparam logic [2:0]  SRC_CFG_BLANK = 3'h7;
  localparam logic [1:0]  MON_SW_ONLY   = 2'h1;
  localparam logic [1:0]  MON_ALL_ON    = 2'h0;
  // Wake delay, within the 2 to 4 cycle window.
  localparam int WAKE_NS = 300;
  localparam int CLK_NS = 100;
  localparam logic [1:0]  WAKE_CYC = 2'((WAKE_NS + CLK_NS - 1) / CLK_NS - 1);
  // Power-save states.
  typedef enum logic [1:0] {PS_RUN, PS_IDLE, PS_WAKE} scdc_ps_e;
  // Source ticks from the oscillator logic.
  typedef struct packed {
    logic fast_internal_rc;
    logic primary;
    logic secondary;
    logic slow_rc;
    logic pll;
  } scdc_ticks_s;
endpackage

// ===== test/scdc_properties.sv
// Concurrent checks on the ports of the clock and doze controller.
// Assumes one clock domain; either reset pauses every check.
`timescale 1ns/1ps
`default_nettype none
module scdc_properties
  import scdc_pkg::*;
(
  // Clock and resets.
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        por,
  // Stimulus seen by the block.
  input wire scdc_ticks_s ticks,
  input wire logic        idle_request,
  input wire logic        irq_pending,
  input wire logic        reset_event,
  input wire logic        watchdog_timeout,
  // Outputs under check.
  input wire logic        instruction_clock,
  input wire logic        periph_clock,
  input wire logic        cpu_clock,
  input wire logic        pll_enable,
  input wire logic        pll_from_primary,
  input wire logic        divided_fast_rc,
  input wire logic        watchdog_ref_tick,
  input wire logic        slow_rc_run,
  input wire logic        watchdog_clear,
  input wire logic        cpu_resume,
  input wire logic        idle_active
);
  // Every check samples on the rising edge and pauses under either reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);

  AST_IDLE_CLEAR: assert property (idle_request && !idle_active |=> watchdog_clear && idle_active)
    else $error("Idle entry did not clear the watchdog.");
  AST_IDLE_HALT: assert property (idle_active && $past(idle_active) |-> !cpu_clock)
    else $error("CPU clock ran while idle.");
  AST_WAKE: assert property (idle_active && (irq_pending || reset_event || watchdog_timeout) |-> ##[1:4] cpu_resume)
    else $error("No resume after a wake cause.");
  AST_RESUME: assert property (cpu_resume |-> !idle_active && $past(idle_active) && $past(idle_active, 2) && $past(idle_active, 3))
    else $error("Resume came at the wrong distance from wake.");
  AST_PERIPH_SYNC: assert property (instruction_clock == periph_clock)
    else $error("Peripheral and instruction clocks differ.");
  // A slowed CPU tick must still fall on an instruction tick, or the domains drift apart.
  AST_CPU_SYNC: assert property (cpu_clock |-> instruction_clock)
    else $error("CPU tick outside an instruction tick.");
  AST_INSTR_HALF: assert property (instruction_clock |=> !instruction_clock)
    else $error("Instruction clock faster than source over two.");
  AST_WD_REF: assert property (ticks.slow_rc && slow_rc_run ##1 slow_rc_run |-> watchdog_ref_tick)
    else $error("Slow RC tick did not reach the watchdog.");
  AST_PLL_SRC: assert property (pll_from_primary |-> pll_enable)
    else $error("Primary routed to a disabled PLL.");
  AST_FRC_DIV: assert property (divided_fast_rc |=> !divided_fast_rc)
    else $error("Fast RC divider below 1:2.");

  // Main scenarios reached.
  cover property (watchdog_clear);
  cover property (cpu_resume);
  cover property (pll_enable && instruction_clock);
endmodule
`default_nettype wire

// ===== test/scdc_top_tb_top.sv
// Self-checking bench for the clock and doze controller, driven at its register port.
// Assumes the package and checker are compiled first; source ticks are made here.
`timescale 1ns/1ps
`default_nettype none
module scdc_top_tb_top
  import scdc_pkg::*;
;
  // Stimulus, all given a value at time zero.
  logic        clk = 1'b0, rst = 1'b1, por = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        watchdog_enable = 1'b0, idle_request = 1'b0, irq_pending = 1'b0;
  logic        reset_event = 1'b0, watchdog_timeout = 1'b0, pll_locked = 1'b1, clock_fail_event = 1'b0;
  logic [1:0]  addr = 2'h0, primary_mode_config = PRI_MODE_OFF, switch_monitor_config = MON_ALL_ON;
  logic [2:0]  reset_source_config = SRC_CFG_BLANK;
  logic [15:0] wdata = 16'h0000, cyc = 16'h0000;
  scdc_ticks_s ticks = '0;
  // Design outputs.
  logic [15:0] rdata, pin_select_value;
  logic        instruction_clock, periph_clock, cpu_clock, pll_enable, pll_from_primary, divided_fast_rc;
  logic        watchdog_ref_tick, slow_rc_run, watchdog_clear, cpu_resume, idle_active, pin_select_lock;
  // Bookkeeping; pulse counters stay four-state so an unknown output spoils the sum.
  int          mismatches = 0, check_count = 0, n;
  logic [15:0] cnt [4];

  scdc_top i_scdc_top (.clk(clk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .reset_source_config(reset_source_config), .primary_mode_config(primary_mode_config),
    .switch_monitor_config(switch_monitor_config), .watchdog_enable(watchdog_enable), .ticks(ticks),
    .pll_locked(pll_locked), .clock_fail_event(clock_fail_event), .idle_request(idle_request),
    .irq_pending(irq_pending), .reset_event(reset_event), .watchdog_timeout(watchdog_timeout),
    .instruction_clock(instruction_clock), .periph_clock(periph_clock), .cpu_clock(cpu_clock),
    .pll_enable(pll_enable), .pll_from_primary(pll_from_primary), .divided_fast_rc(divided_fast_rc),
    .watchdog_ref_tick(watchdog_ref_tick), .slow_rc_run(slow_rc_run), .watchdog_clear(watchdog_clear),
    .cpu_resume(cpu_resume), .idle_active(idle_active), .pin_select_lock(pin_select_lock),
    .pin_select_value(pin_select_value));

  // 100 ns clock.
  always #50 clk = ~clk;

  // Fast RC and PLL tick every cycle, primary every second, slow RC every sixteenth.
  // The cycle count also cuts a hang short, well above the roughly 7000 cycles needed.
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    ticks <= {1'b1, ~cyc[0], cyc[2:0] == 3'h0, cyc[3:0] == 4'h0, 1'b1};
    if (cyc == 16'h4E20) begin
      mismatches++;
      finish_test();
    end
  end

  // Counts one comparison and reports a difference at once.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write; the strobe drops before any next request.
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, rdata, exp);
  endtask

  // Oscillator control write behind the two-key unlock.
  task automatic osc_wr(input logic [15:0] d);
    reg_wr(ADDR_UNLOCK, UNLOCK_KEY1);
    reg_wr(ADDR_UNLOCK, UNLOCK_KEY2);
    reg_wr(ADDR_OSC_CTRL, d);
  endtask

  // Two-cycle reset; configuration only counts while power-on reset is high.
  task automatic do_reset(input logic p, input logic [2:0] s, input logic [1:0] m);
    @(posedge clk);
    rst <= 1'b1;
    por <= p;
    reset_source_config <= s;
    primary_mode_config <= m;
    switch_monitor_config <= MON_SW_ONLY;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
  endtask

  // Counts instruction, peripheral, CPU and divided fast RC pulses.
  task automatic count_clk(input int cycles);
    cnt = '{default: 16'h0000};
    repeat (cycles) begin
      @(negedge clk);
      cnt[0] = cnt[0] + instruction_clock;
      cnt[1] = cnt[1] + periph_clock;
      cnt[2] = cnt[2] + cpu_clock;
      cnt[3] = cnt[3] + divided_fast_rc;
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    // Blank configuration falls back to fast RC; divider register at defaults.
    rd_chk(ADDR_OSC_CTRL, 16'h0000, "osc_blank");
    rd_chk(ADDR_CLK_DIV, 16'h0000, "div_reset");
    rd_chk(ADDR_UNLOCK, 16'h0000, "unlock_read");
    chk("slow_run_mon", slow_rc_run, 16'h0001);
    count_clk(40);
    chk("fcy_frc", cnt[0], 16'h0014);
    do_reset(1'b1, SRC_SLOW, PRI_MODE_OFF);
    rd_chk(ADDR_OSC_CTRL, 16'h5500, "osc_slow");
    chk("slow_run_off", slow_rc_run, 16'h0000);
    @(posedge clk);
    watchdog_enable <= 1'b1;
    @(negedge clk);
    chk("slow_run_wd", slow_rc_run, 16'h0001);
    do_reset(1'b1, SRC_PRI, 2'h0);
    rd_chk(ADDR_OSC_CTRL, 16'h2200, "osc_pri");
    count_clk(40);
    chk("fcy_pri", cnt[0], 16'h000A);
    // Without the keys the write is dropped.
    reg_wr(ADDR_OSC_CTRL, 16'h0101);
    rd_chk(ADDR_OSC_CTRL, 16'h2200, "osc_locked");
    // Primary to fast RC with PLL; no direct PLL to PLL switch is ever made.
    osc_wr(16'h0101);
    rd_chk(ADDR_OSC_CTRL, 16'h1120, "osc_frcpll");
    // Out of lock the status bit must read low.
    @(posedge clk);
    pll_locked <= 1'b0;
    rd_chk(ADDR_OSC_CTRL, 16'h1100, "osc_nolock");
    @(posedge clk);
    pll_locked <= 1'b1;
    chk("pll_en", pll_enable, 16'h0001);
    chk("pll_pri", pll_from_primary, 16'h0000);
    count_clk(40);
    chk("fcy_pll", cnt[0], 16'h0014);
    // Switch lock freezes the source and keeps the request pending.
    osc_wr(16'h0180);
    osc_wr(16'h0081);
    rd_chk(ADDR_OSC_CTRL, 16'h10A1, "osc_frozen");
    osc_wr(16'h0001);
    rd_chk(ADDR_OSC_CTRL, 16'h0000, "osc_free");
    // Pin-select writes land only while unlocked.
    reg_wr(ADDR_PIN_SEL, 16'h1234);
    @(negedge clk);
    chk("pin_open", pin_select_value, 16'h1234);
    osc_wr(16'h0040);
    @(negedge clk);
    chk("pin_lock", pin_select_lock, 16'h0001);
    reg_wr(ADDR_PIN_SEL, 16'hABCD);
    @(negedge clk);
    chk("pin_shut", pin_select_value, 16'h1234);
    // A plain reset leaves oscillator control alone.
    do_reset(1'b0, SRC_PRI, 2'h0);
    rd_chk(ADDR_OSC_CTRL, 16'h0040, "osc_kept");
    // Every doze and divider code; windows are whole periods after a settling gap.
    for (int c = 0; c < 8; c++) begin
      reg_wr(ADDR_CLK_DIV, {1'b0, 3'(c), 1'b1, 3'(c), 8'h00});
      rd_chk(ADDR_CLK_DIV, {1'b0, 3'(c), 1'b1, 3'(c), 8'h00}, "div_back");
      repeat (256) @(posedge clk);
      count_clk(512);
      chk("fcy_doze", cnt[0], 16'h0100);
      chk("periph_doze", cnt[1], 16'h0100);
      chk("cpu_doze", cnt[2], 16'h0100 >> c);
      chk("frc_div", cnt[3], 16'h0200 >> (c + 1));
    end
    // Return-on-interrupt set, then clear.
    for (int r = 1; r >= 0; r--) begin
      reg_wr(ADDR_CLK_DIV, r ? 16'hB800 : 16'h3800);
      @(posedge clk);
      irq_pending <= 1'b1;
      @(posedge clk);
      irq_pending <= 1'b0;
      rd_chk(ADDR_CLK_DIV, r ? 16'hB000 : 16'h3800, "roi");
    end
    // Idle, woken by interrupt, reset, watchdog time-out, and an interrupt at entry.
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      idle_request <= 1'b1;
      irq_pending <= (k == 3);
      @(posedge clk);
      idle_request <= 1'b0;
      @(negedge clk);
      chk("wd_clear", watchdog_clear, 16'h0001);
      chk("idle_on", idle_active, 16'h0001);
      if (k < 3) begin
        repeat (5) @(negedge clk);
        chk("idle_hold", idle_active, 16'h0001);
        @(posedge clk);
        irq_pending <= (k == 0);
        reset_event <= (k == 1);
        watchdog_timeout <= (k == 2);
      end
      n = 0;
      @(negedge clk);
      while (cpu_resume !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      chk("resumed", 16'(n < 10), 16'h0001);
      if (k < 3) chk("wake_delay", 16'(n >= 2 && n <= 4), 16'h0001);
      @(posedge clk);
      irq_pending <= 1'b0;
      reset_event <= 1'b0;
      watchdog_timeout <= 1'b0;
    end
    // Sources 4 to 7 over 64 cycles each; none passes the PLL, so no PLL to PLL step.
    for (int s = 4; s < 8; s++) begin
      osc_wr({5'h00, 3'(s), 8'h01});
      rd_chk(ADDR_OSC_CTRL, {1'b0, 3'(s), 1'b0, 3'(s), 8'h00}, "osc_src");
      repeat (40) @(posedge clk);
      count_clk(64);
      chk("fcy_src", cnt[0], (s == 7) ? 16'h0010 : (s == 4) ? 16'h0004 : 16'h0002);
    end
    finish_test();
  end
endmodule

bind scdc_top scdc_properties i_scdc_properties (.clk(clk), .rst(rst), .por(por), .ticks(ticks),
  .idle_request(idle_request), .irq_pending(irq_pending), .reset_event(reset_event),
  .watchdog_timeout(watchdog_timeout), .instruction_clock(instruction_clock), .periph_clock(periph_clock),
  .cpu_clock(cpu_clock), .pll_enable(pll_enable), .pll_from_primary(pll_from_primary),
  .divided_fast_rc(divided_fast_rc), .watchdog_ref_tick(watchdog_ref_tick), .slow_rc_run(slow_rc_run),
  .watchdog_clear(watchdog_clear), .cpu_resume(cpu_resume), .idle_active(idle_active));
`default_nettype wire
